// ===== src/line_supv_pkg.sv
/*
 * Shared constants and carriers for the line supervision status logic:
 * register offsets, control and status word layouts, reset values and
 * timing figures. Assumes a 100 MHz system clock.
 */
package line_supv_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Combined control write / status read word
    localparam logic [ADDR_W-1:0] REG_CTRL_STATUS = 4'h0;
    // Quick status read, hook bit only, no shifting of the control word
    localparam logic [ADDR_W-1:0] REG_QUICK_STATUS = 4'h4;

    // Operating mode field (mode_ctrl_hi, mode_ctrl_lo)
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_REVERSE = 2'h1;
    localparam logic [1:0] MODE_DENIAL = 2'h2;
    localparam logic [1:0] MODE_ONHOOK_TX = 2'h3;

    // Control word written by the line-card controller
    typedef struct packed {
        logic ground_start;  // Loop detector threshold select
        logic relay2_on;     // Auxiliary relay 2
        logic relay1_on;     // Auxiliary relay 1
        logic ring_mode;     // ring_mode_ctrl
        logic [1:0] mode;    // {mode_ctrl_hi, mode_ctrl_lo}
        logic [1:0] balance; // Hybrid balance network
    } ctrl_s;

    // Status word returned on a status read
    typedef struct packed {
        logic hook;          // hook_status_bit
        logic relay2_on;
        logic relay1_on;
        logic ring_mode;
        logic [1:0] mode;    // {mode_status_hi, mode_status_lo}
        logic [1:0] balance;
    } status_s;

    // Values after reset
    localparam ctrl_s CTRL_RESET = 8'h00;
    localparam logic HOOK_RESET = 1'b1;

    // Ring trip needs this many consecutive negative ring periods
    localparam int TRIP_PERIODS = 2;
    localparam int TRIP_CNT_W = 2;

    // Master clock watchdog: relay off if master_clk stalls longer
    localparam int CLK_PERIOD_NS = 10;
    localparam int MCLK_STALL_US = 200;
    // Longest time, so round down
    localparam int MCLK_STALL_CYCLES = MCLK_STALL_US * 1000 / CLK_PERIOD_NS;
    localparam int STALL_CNT_W = 16;

endpackage

// ===== src/line_supv_status.sv
/*
 * Status and interrupt logic of a subscriber line interface: hook and
 * ring trip reporting, thermal power denial, on-hook transmission and
 * the master clock watchdog for the ring relay.
 * Assumes all inputs are synchronous to clock, the analog supervision
 * circuits deliver clean levels and one-cycle ring period pulses, and
 * the controller holds control_select_n low around its accesses.
 */
//
// Overview of operation
// (R1) Off-hook powers up, interrupts, clears hook bit
// (R2) Interrupt held until status read under select
// (R3) On-hook powers down, sets hook bit, interrupts
// (R4) Hook reverting before read withdraws interrupt
// (R5) Off-hook under select: interrupt now, bit later
// (R6) Deferred update latched on next combined access
// (R7) Two negative ring periods declare ring trip
// (R8) Ring trip: relay off, bit cleared, interrupt
// (R9) Ring mode stays set until controller clears
// (R10) After trip hook bit zero until ring cleared
// (R11) After ring exit off-hook clears bit, interrupts
// (R12) Stalled master clock turns ring relay off
// (R13) Overload forces power denial and interrupts
// (R14) Overload interrupt released when select falls
// (R15) Writes cannot leave denial during overload
// (R16) Denial persists; overload end interrupts again
// (R17) Writing normal mode clears both mode bits
// (R18) Overload under select: interrupt now, status later
// (R19) Both mode bits on-hook: reduced power transmission
// (R20) Off-hook in transmission powers drivers, interrupts
// (R21) Hook bit one on-hook, zero off-hook or trip
// (R22) Ring mode energises relay and ring supervision
// (R23) Quick read returns hook bit only
// (R24) Interrupt low while any event unserviced
// (R25) Controller compares status words to find cause
`timescale 1ns/1ns

module line_supv_status
    import line_supv_pkg::*;
#(
    parameter int STALL_CYCLES = MCLK_STALL_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    // Control port select, low during an access
    input wire logic control_select_n,
    // Analog supervision results
    input wire logic loop_off_hook,
    input wire logic ring_sense_neg_a,
    input wire logic ring_sense_neg_b,
    input wire logic ring_period_end,
    input wire logic thermal_overload,
    input wire logic master_clk,
    // Outputs
    output logic line_event_irq_n,
    output logic ring_relay_drive,
    output logic ring_supv_enable,
    output logic circuit_power_up,
    output logic line_driver_on,
    output logic line_driver_low_power,
    output logic relay1_drive,
    output logic relay2_drive
);

    // Elaboration check: the watchdog counter must hold the limit
    if (STALL_CYCLES < 2 || STALL_CYCLES >= (1 << STALL_CNT_W) - 1) begin
        $error("STALL_CYCLES out of range");
    end

    ctrl_s ctrl_q;             // Control word
    logic hook_status_bit_q;   // Reported hook bit
    logic latched_off_q;       // Off-hook state at last service read
    logic deferred_q;          // Hook bit update waited for select high
    logic ring_trip_q;         // Ring trip seen, cleared with ring mode
    logic trip_pend_q;         // Ring trip not yet serviced
    logic therm_pend_q;        // Overload edge not yet serviced
    logic therm_prev_q;        // Overload level one cycle ago
    logic sel_prev_n_q;        // Select level one cycle ago
    logic [TRIP_CNT_W-1:0] trip_cnt_q; // Consecutive negative periods
    logic [STALL_CNT_W-1:0] stall_cnt_q; // Cycles without mclk change
    logic mclk_prev_q;         // Master clock level one cycle ago
    logic mclk_stall_q;        // Master clock considered stopped

    // Access qualifiers; accesses without select are ignored
    logic selected;
    logic ctrl_wr;
    logic status_rd;
    logic quick_rd;
    assign selected = !control_select_n;
    assign ctrl_wr = selected && reg_write && reg_addr == REG_CTRL_STATUS;
    assign status_rd = selected && reg_read && reg_addr == REG_CTRL_STATUS;
    assign quick_rd = selected && reg_read && reg_addr == REG_QUICK_STATUS;

    // Loop supervision is off the line during ringing
    logic off_hook;
    assign off_hook = loop_off_hook && !ctrl_q.ring_mode; // R11

    // Hook event pending while state differs from the serviced one
    logic hook_pend;
    assign hook_pend = off_hook != latched_off_q; // R4

    // Ring trip decision at the end of a ring period
    logic ring_neg;
    logic trip_event;
    assign ring_neg = ring_sense_neg_a || ring_sense_neg_b;
    assign trip_event = ctrl_q.ring_mode && !ring_trip_q &&
        ring_period_end && ring_neg &&
        trip_cnt_q == TRIP_CNT_W'(TRIP_PERIODS - 1); // R7

    // Either edge of the overload condition is an event
    logic therm_edge;
    assign therm_edge = thermal_overload != therm_prev_q; // R13 R16

    // Select falling edge services the overload event
    logic sel_fall;
    assign sel_fall = sel_prev_n_q && !control_select_n;

    // Mode field after a write; overload keeps power denial
    logic [1:0] mode_wr;
    assign mode_wr = thermal_overload ? MODE_DENIAL : reg_wdata[3:2]; // R15

    // Status word as seen by the controller
    status_s status_word;
    assign status_word = '{hook: hook_status_bit_q,
        relay2_on: ctrl_q.relay2_on, relay1_on: ctrl_q.relay1_on,
        ring_mode: ctrl_q.ring_mode, mode: ctrl_q.mode,
        balance: ctrl_q.balance};

    // Control word: writes, overload forcing deferred under select
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (ctrl_wr) begin
            // Ring mode leaves only by an explicit write
            ctrl_q <= reg_wdata; // R9 R22
            ctrl_q.mode <= mode_wr; // R15 R17
        end else if (thermal_overload && control_select_n) begin
            // Forced denial only once the port is released
            ctrl_q.mode <= MODE_DENIAL; // R13 R18
        end
    end

    // Consecutive negative ring period counter
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            trip_cnt_q <= '0;
        end else if (!ctrl_q.ring_mode || ring_trip_q) begin
            trip_cnt_q <= '0;
        end else if (ring_period_end) begin
            // Any positive period restarts the count
            trip_cnt_q <= ring_neg ? trip_cnt_q + 1'b1 : '0; // R7
        end
    end

    // Ring trip flag, cleared by writing ring mode off
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ring_trip_q <= 1'b0;
        end else if (trip_event) begin
            ring_trip_q <= 1'b1; // R8
        end else if (ctrl_wr && !reg_wdata[4]) begin
            ring_trip_q <= 1'b0; // R10
        end
    end

    // Hook bit; frozen while the port is selected
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hook_status_bit_q <= HOOK_RESET;
        end else if (control_select_n) begin
            // Trip forces zero until ring mode is cleared
            hook_status_bit_q <= !(ring_trip_q || off_hook); // R1 R3 R5 R10 R21
        end
    end

    // Deferred update tracking for the next combined access
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            deferred_q <= 1'b0;
        end else if (selected && hook_status_bit_q == off_hook) begin
            // Set wins over the clear of the same cycle
            deferred_q <= 1'b1;
        end else if (ctrl_wr) begin
            deferred_q <= 1'b0; // R6
        end
    end

    // Serviced hook state, latched by a status read or combined access
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            latched_off_q <= 1'b0;
        end else if (status_rd || (ctrl_wr && deferred_q)) begin
            // A quick read services nothing; the hook bit alone is shown
            latched_off_q <= off_hook; // R2 R6
        end
    end

    // Ring trip pending; a new trip wins over the read
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            trip_pend_q <= 1'b0;
        end else if (trip_event) begin
            trip_pend_q <= 1'b1; // R8
        end else if (status_rd) begin
            trip_pend_q <= 1'b0; // R2
        end
    end

    // Overload pending; released as soon as select goes low
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            therm_pend_q <= 1'b0;
            therm_prev_q <= 1'b0;
            sel_prev_n_q <= 1'b1;
        end else begin
            therm_prev_q <= thermal_overload;
            sel_prev_n_q <= control_select_n;
            if (therm_edge) begin
                therm_pend_q <= 1'b1; // R13 R16 R18
            end else if (sel_fall) begin
                therm_pend_q <= 1'b0; // R14
            end
        end
    end

    // Interrupt level from all pending events
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            line_event_irq_n <= 1'b1;
        end else begin
            // Trip and overload edges count in their own cycle, so the
            // pin falls on the edge after the event, as a hook change does
            line_event_irq_n <= !(hook_pend || trip_pend_q || trip_event ||
                therm_pend_q || therm_edge); // R1 R3 R5 R8 R13 R18 R20 R24
        end
    end

    // Master clock watchdog; counts cycles without a level change
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mclk_prev_q <= 1'b0;
            stall_cnt_q <= '0;
            mclk_stall_q <= 1'b0;
        end else begin
            mclk_prev_q <= master_clk;
            // Any level change restarts the count, high or low stalls alike
            if (master_clk != mclk_prev_q) begin
                stall_cnt_q <= '0;
                mclk_stall_q <= 1'b0;
            end else if (stall_cnt_q != STALL_CNT_W'(STALL_CYCLES)) begin
                stall_cnt_q <= stall_cnt_q + 1'b1;
            end else begin
                // More than the limit: saturate and flag
                mclk_stall_q <= 1'b1; // R12
            end
        end
    end

    // Relay and power outputs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ring_relay_drive <= 1'b0;
            ring_supv_enable <= 1'b0;
            circuit_power_up <= 1'b0;
            line_driver_on <= 1'b0;
            line_driver_low_power <= 1'b0;
            relay1_drive <= 1'b0;
            relay2_drive <= 1'b0;
        end else begin
            // Trip or a stopped master clock drops the relay at once
            ring_relay_drive <= ctrl_q.ring_mode && !ring_trip_q &&
                !trip_event && !mclk_stall_q; // R8 R12 R22
            ring_supv_enable <= ctrl_q.ring_mode && !ring_trip_q; // R22
            // Standby powers down all but supervision when on-hook
            circuit_power_up <= off_hook || ctrl_q.ring_mode ||
                ctrl_q.mode == MODE_ONHOOK_TX; // R1 R3 R19
            line_driver_on <= ctrl_q.mode != MODE_DENIAL; // R13
            line_driver_low_power <= ctrl_q.mode == MODE_ONHOOK_TX &&
                !ctrl_q.ring_mode && !off_hook; // R19 R20
            relay1_drive <= ctrl_q.relay1_on;
            relay2_drive <= ctrl_q.relay2_on;
        end
    end

    // Read data, valid in the cycle after the read strobe only
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (status_rd) begin
            reg_rdata <= status_word;
        end else if (quick_rd) begin
            reg_rdata <= {hook_status_bit_q, 7'h00}; // R23
        end else begin
            // Data stand one cycle only, so a stale word is never read twice
            reg_rdata <= '0;
        end
    end

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // A new off-hook against a serviced on-hook; a reverting change
    // withdraws its own interrupt and is not covered here
    sequence s_offhook_unread;
        $rose(off_hook) && !latched_off_q && !status_rd && !ctrl_wr;
    endsequence

    chk_irq_on_offhook: assert property (s_offhook_unread |=> // R1
        !line_event_irq_n)
        else $error("no interrupt after off-hook");

    chk_irq_has_cause: assert property (!line_event_irq_n |-> // R24
        $past(hook_pend || trip_pend_q || trip_event ||
        therm_pend_q || therm_edge))
        else $error("interrupt without pending event");

    chk_hook_defer: assert property ($past(!control_select_n) |-> // R5
        $stable(hook_status_bit_q))
        else $error("hook bit changed while selected");

    chk_trip_relay: assert property (trip_event |=> // R8
        !ring_relay_drive && !line_event_irq_n && ring_trip_q)
        else $error("ring trip did not drop relay");

    chk_trip_hold: assert property ($past(ring_trip_q) && // R10
        $past(control_select_n) |-> !hook_status_bit_q)
        else $error("hook bit set after ring trip");

    chk_mclk_stall: assert property (mclk_stall_q |=> // R12
        !ring_relay_drive)
        else $error("relay on with stopped master clock");

    chk_overload_force: assert property ($past(thermal_overload) && // R15
        ($past(control_select_n) || $past(ctrl_wr)) |->
        ctrl_q.mode == MODE_DENIAL)
        else $error("power denial not held under overload");

    chk_normal_restore: assert property (ctrl_wr && // R17
        !thermal_overload && reg_wdata[3:2] == MODE_NORMAL |=>
        ctrl_q.mode == MODE_NORMAL)
        else $error("normal mode write not taken");

    chk_quick_read: assert property (quick_rd |=> // R23
        reg_rdata[6:0] == 7'h00)
        else $error("quick read returned control bits");

    // Select falling services a lone overload event
    chk_overload_release: assert property (sel_fall && !therm_edge |=> // R14
        !therm_pend_q)
        else $error("overload interrupt not released by select");

    // Power denial must take the line drivers off
    chk_denial_drivers: assert property ( // R13
        ctrl_q.mode == MODE_DENIAL |=> !line_driver_on)
        else $error("line drivers on in power denial");

    // On-hook transmission keeps circuits up at reduced driver power
    chk_onhook_tx: assert property ( // R19
        ctrl_q.mode == MODE_ONHOOK_TX && !ctrl_q.ring_mode && !off_hook |=>
        line_driver_low_power && circuit_power_up)
        else $error("on-hook transmission power state wrong");

    // Ring mode with no trip and a live master clock energises the relay
    chk_ring_relay_on: assert property ( // R22
        ctrl_q.ring_mode && !ring_trip_q && !trip_event && !mclk_stall_q |=>
        ring_relay_drive && ring_supv_enable)
        else $error("ring relay not energised in ring mode");

endmodule

// ===== verification/line_side_model.sv
/*
 * Behavioural model of the line side of the status logic: loop and
 * ring supervision results and the master clock, steered by the bench.
 * Assumes one clock domain; the bench changes the request inputs just
 * after a rising edge.
 */
`timescale 1ns/1ns

module line_side_model (
    // Clock
    input wire logic clock,
    // Requests from the bench
    input wire logic off_hook_req,
    input wire logic [1:0] trip_req,
    input wire logic mclk_run,
    // Supervision results toward the device
    output logic loop_off_hook,
    output logic ring_sense_neg_a,
    output logic ring_sense_neg_b,
    output logic ring_period_end,
    output logic master_clk
);
    // Position inside a short ring period of eight cycles
    logic [2:0] phase_q = 3'h0;

    // Clean loop result, no dial bounce modelled
    assign loop_off_hook = off_hook_req;
    // Each integrated result held negative while its own trip_req bit is set
    assign ring_sense_neg_a = trip_req[0];
    assign ring_sense_neg_b = trip_req[1];

    // Ring period pulse, one cycle long at the end of each period
    always @(posedge clock) begin
        phase_q <= phase_q + 3'h1;
        ring_period_end <= (phase_q == 3'h7);
    end

    // Master clock toggles only while running; a stop freezes its level
    initial master_clk = 1'b0;
    always @(posedge clock) begin
        if (mclk_run) begin
            master_clk <= ~master_clk;
        end
    end
endmodule

// ===== verification/tb_line_supv_status.sv
/*
 * Self-checking bench for the line supervision status logic: register
 * accesses under port select, hook, ring trip, overload and on-hook
 * transmission sequences. Assumes the line side model beside it and a
 * shortened master clock stall count.
 */
`timescale 1ns/1ns

module tb_line_supv_status;
    import line_supv_pkg::*;

    // Short stall count keeps the watchdog run brief
    localparam int STALL = 20;

    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic control_select_n = 1'b1;
    logic thermal_overload = 1'b0;
    logic off_hook_req = 1'b0;
    logic [1:0] trip_req = 2'h0;
    logic mclk_run = 1'b1;
    logic hold_sel = 1'b0; // Keeps select low after an access
    logic [DATA_W-1:0] reg_rdata;
    logic loop_off_hook, ring_sense_neg_a, ring_sense_neg_b;
    logic ring_period_end, master_clk, line_event_irq_n;
    logic ring_relay_drive, ring_supv_enable, circuit_power_up;
    logic line_driver_on, line_driver_low_power;
    logic relay1_drive, relay2_drive;
    int num_errors = 0;
    int cmp_count = 0;

    // Free running 100 MHz clock
    always #5 clock = ~clock;

    line_side_model partner (.clock(clock), .off_hook_req(off_hook_req),
        .trip_req(trip_req), .mclk_run(mclk_run),
        .loop_off_hook(loop_off_hook), .ring_sense_neg_a(ring_sense_neg_a),
        .ring_sense_neg_b(ring_sense_neg_b),
        .ring_period_end(ring_period_end), .master_clk(master_clk));

    line_supv_status #(.STALL_CYCLES(STALL)) DUT (.clock(clock),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .control_select_n(control_select_n),
        .loop_off_hook(loop_off_hook), .ring_sense_neg_a(ring_sense_neg_a),
        .ring_sense_neg_b(ring_sense_neg_b),
        .ring_period_end(ring_period_end),
        .thermal_overload(thermal_overload), .master_clk(master_clk),
        .line_event_irq_n(line_event_irq_n),
        .ring_relay_drive(ring_relay_drive),
        .ring_supv_enable(ring_supv_enable),
        .circuit_power_up(circuit_power_up),
        .line_driver_on(line_driver_on),
        .line_driver_low_power(line_driver_low_power),
        .relay1_drive(relay1_drive), .relay2_drive(relay2_drive));

    // Compare one value and count it
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One access under select; values sampled at edges, before updates
    task access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                output logic [7:0] q);
        @(posedge clock);
        control_select_n <= 1'b0;
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= wr;
        reg_read <= ~wr;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        @(posedge clock);
        q = reg_rdata;
        control_select_n <= hold_sel ? 1'b0 : 1'b1;
    endtask

    task rd(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] q;
        access(1'b0, a, 8'h00, q);
        chk("rdata", exp, q);
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, a, d, q);
        repeat (2) @(posedge clock);
    endtask

    // Quick read: only the hook bit may be non-zero
    task quick(input logic hook);
        logic [7:0] q;
        access(1'b0, REG_QUICK_STATUS, 8'h00, q);
        chk("quick", {hook, 7'h00}, q);
    endtask

    // Wait a bounded number of cycles for the interrupt level
    task waitirq(input logic v, input int n);
        int i;
        i = 0;
        while (line_event_irq_n !== v && i < n) begin
            @(posedge clock);
            i++;
        end
        chk("irq_n", {7'h00, v}, {7'h00, line_event_irq_n});
    endtask

    // Hook change, serviced by a status read
    task svc(input logic off, input logic [7:0] st);
        @(posedge clock);
        off_hook_req <= off;
        waitirq(1'b0, 4);
        rd(REG_CTRL_STATUS, st);
        waitirq(1'b1, 4);
    endtask

    task summarize;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, far beyond the length of the sequence
    initial begin
        repeat (6000) @(posedge clock);
        num_errors++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        waitirq(1'b1, 1);
        rd(REG_CTRL_STATUS, 8'h80);
        wr(REG_CTRL_STATUS, 8'h63);
        chk("relays", 8'h03, {6'h00, relay2_drive, relay1_drive});
        wr(REG_QUICK_STATUS, 8'h00);
        rd(REG_CTRL_STATUS, 8'he3);
        rd(4'h8, 8'h00);
        wr(REG_CTRL_STATUS, 8'h00);
        quick(1'b1);
        svc(1'b1, 8'h00);
        chk("power_up", 8'h01, {7'h00, circuit_power_up});
        off_hook_req <= 1'b0;
        waitirq(1'b0, 4);
        chk("power_up", 8'h00, {7'h00, circuit_power_up});
        off_hook_req <= 1'b1;
        waitirq(1'b1, 4);
        svc(1'b0, 8'h80);
        hold_sel <= 1'b1;
        control_select_n <= 1'b0;
        off_hook_req <= 1'b1;
        waitirq(1'b0, 4);
        quick(1'b1);
        @(posedge clock);
        hold_sel <= 1'b0;
        control_select_n <= 1'b1;
        repeat (3) @(posedge clock);
        quick(1'b0);
        wr(REG_CTRL_STATUS, 8'h00);
        waitirq(1'b1, 4);
        svc(1'b0, 8'h80);
        wr(REG_CTRL_STATUS, 8'h10);
        chk("ring", 8'h03, {6'h00, ring_relay_drive, ring_supv_enable});
        trip_req <= 2'h2;
        waitirq(1'b0, 40);
        chk("relay", 8'h00, {7'h00, ring_relay_drive});
        trip_req <= 2'h0;
        rd(REG_CTRL_STATUS, 8'h10);
        waitirq(1'b1, 4);
        wr(REG_CTRL_STATUS, 8'h00);
        rd(REG_CTRL_STATUS, 8'h80);
        waitirq(1'b1, 4);
        svc(1'b1, 8'h00);
        wr(REG_CTRL_STATUS, 8'h10);
        chk("relay", 8'h01, {7'h00, ring_relay_drive});
        mclk_run <= 1'b0;
        repeat (STALL - 5) @(posedge clock);
        chk("relay", 8'h01, {7'h00, ring_relay_drive});
        repeat (10) @(posedge clock);
        chk("relay", 8'h00, {7'h00, ring_relay_drive});
        mclk_run <= 1'b1;
        wr(REG_CTRL_STATUS, 8'h00);
        waitirq(1'b0, 8);
        rd(REG_CTRL_STATUS, 8'h00);
        waitirq(1'b1, 4);
        thermal_overload <= 1'b1;
        waitirq(1'b0, 3);
        rd(REG_CTRL_STATUS, 8'h08);
        chk("driver", 8'h00, {7'h00, line_driver_on});
        waitirq(1'b1, 3);
        wr(REG_CTRL_STATUS, 8'h00);
        rd(REG_CTRL_STATUS, 8'h08);
        thermal_overload <= 1'b0;
        waitirq(1'b0, 3);
        rd(REG_CTRL_STATUS, 8'h08);
        wr(REG_CTRL_STATUS, 8'h00);
        rd(REG_CTRL_STATUS, 8'h00);
        chk("driver", 8'h01, {7'h00, line_driver_on});
        svc(1'b0, 8'h80);
        wr(REG_CTRL_STATUS, 8'h0c);
        chk("low_power", 8'h01, {7'h00, line_driver_low_power});
        chk("power_up", 8'h01, {7'h00, circuit_power_up});
        svc(1'b1, 8'h0c);
        chk("low_power", 8'h00, {7'h00, line_driver_low_power});
        summarize();
    end
endmodule
